//--- hw/ppm_port_mode.sv
// port pin mode block: drive mode, analog select and pin level readback
// assumes a single AHB-Lite master, word transfers, pads resolved outside
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module ppm_port_mode #(
   parameter logic [31:0] BASE_ADDR = ppm_pkg::BASE_ADDR
) (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   input wire ppm_pkg::ppm_port_word_t pin_level_in,
   input wire ppm_pkg::ppm_pad_ctl_s pad_ctl_in,
   output var ppm_pkg::ppm_pad_drv_s pad_drv_out
);
   import ppm_pkg::*;

   // ------------------------------------------------------------------
   // decode helper
   // ------------------------------------------------------------------
   function automatic logic [NUM_PORTS-1:0] idx_match(
      input logic [IDX_W-1:0] idx,
      input ppm_idx_list_t list,
      input logic [NUM_PORTS-1:0] present
   );
      logic [NUM_PORTS-1:0] hit;
      hit = '0;
      for (int k = 0; k < NUM_PORTS; k++)
      begin
         hit[k] = present[k] && (idx == list[k]);
      end
      return hit;
   endfunction : idx_match

   // ------------------------------------------------------------------
   // bus address phase
   // ------------------------------------------------------------------
   logic in_window;
   logic ap_take;
   logic ap_rd;
   logic ap_wr;
   logic [IDX_W-1:0] ap_idx;
   logic dp_wr_q;
   logic [IDX_W-1:0] dp_idx_q;
   logic [31:0] hrdata_q;
   logic [31:0] hrdata_d;

   // misaligned addresses fall outside the map and read zero; hsize is not decoded
   assign in_window = (haddr_in[31:12] == BASE_ADDR[31:12]) &&
                      (haddr_in[1:0] == 2'h0);
   assign ap_take = hsel_in && hready_in && htrans_in[1];
   assign ap_rd = ap_take && !hwrite_in && in_window;
   assign ap_wr = ap_take && hwrite_in && in_window;
   assign ap_idx = haddr_in[11:2];

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         dp_wr_q <= 1'b0;
         dp_idx_q <= '0;
      end
      else
      begin
         dp_wr_q <= ap_wr;
         dp_idx_q <= ap_idx;
      end
   end

   // ------------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------------
   ppm_port_word_t om_q;
   ppm_port_word_t om_d;
   ppm_port_word_t am_q;
   ppm_port_word_t am_d;
   ppm_port_word_t level_q;
   logic [NUM_PORTS-1:0] wr_om;
   logic [NUM_PORTS-1:0] wr_am;
   logic [NUM_PORTS-1:0] rd_om;
   logic [NUM_PORTS-1:0] rd_am;
   logic [NUM_PORTS-1:0] rd_lv;
   logic [NUM_PORTS:0][PORT_W-1:0] rd_chain;

   // level indices are never decoded for writes, so writes there are lost
   assign wr_om = idx_match(dp_idx_q, OM_IDX, OM_PRESENT) &
                  {NUM_PORTS{dp_wr_q}};
   assign wr_am = idx_match(dp_idx_q, AM_IDX, AM_PRESENT) &
                  {NUM_PORTS{dp_wr_q}};
   assign rd_om = idx_match(ap_idx, OM_IDX, OM_PRESENT) &
                  {NUM_PORTS{ap_rd}};
   assign rd_am = idx_match(ap_idx, AM_IDX, AM_PRESENT) &
                  {NUM_PORTS{ap_rd}};
   assign rd_lv = idx_match(ap_idx, LV_IDX, LV_PRESENT) &
                  {NUM_PORTS{ap_rd}};
   assign rd_chain[0] = '0;

   genvar gk;
   generate
      for (gk = 0; gk < NUM_PORTS; gk++)
      begin : g_reg
         // one bit per pin, bits without a pin stay zero
         assign om_d[gk] = wr_om[gk] ?
                           (hwdata_in[PORT_W-1:0] & PIN_MASK[gk]) :
                           om_q[gk];
         // port H has an all-zero mask so it can never turn analog
         assign am_d[gk] = wr_am[gk] ?
                           (hwdata_in[PORT_W-1:0] & AM_MASK[gk]) :
                           am_q[gk];
         // read the next value so a write just before a read is seen
         assign rd_chain[gk+1] = rd_chain[gk] |
                                 ({PORT_W{rd_om[gk]}} & om_d[gk]) |
                                 ({PORT_W{rd_am[gk]}} & am_d[gk]) |
                                 ({PORT_W{rd_lv[gk]}} &
                                  level_q[gk] & PIN_MASK[gk]);
      end
   endgenerate

   assign hrdata_d = {16'h0000, rd_chain[NUM_PORTS]};

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         om_q <= OM_RST;
         am_q <= AM_RST;
      end
      else
      begin
         om_q <= om_d;
         am_q <= am_d;
      end
   end

   // ------------------------------------------------------------------
   // pin level readback
   // ------------------------------------------------------------------
   // level is the pad itself, so it reads back in output mode too
   ppm_pin_sync #(
      .W(NUM_PORTS * PORT_W)
   ) u_pin_sync (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .async_in(pin_level_in),
      .level_out(level_q)
   );

   // ------------------------------------------------------------------
   // bus data phase
   // ------------------------------------------------------------------
   // zero wait states: hreadyout never drops, every answer is OKAY
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         hrdata_q <= 32'h0000_0000;
      end
      else
      begin
         hrdata_q <= hrdata_d;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         hreadyout_out <= 1'b1;
         hresp_out <= HRESP_OKAY;
      end
      else
      begin
         hreadyout_out <= 1'b1;
         hresp_out <= HRESP_OKAY;
      end
   end

   assign hrdata_out = hrdata_q;

   // ------------------------------------------------------------------
   // pad drive
   // ------------------------------------------------------------------
   ppm_pad_drv_s drv_d;

   generate
      for (gk = 0; gk < NUM_PORTS; gk++)
      begin : g_pad
         logic [PORT_W-1:0] ana;
         logic [PORT_W-1:0] out_mode;
         assign ana = am_q[gk] & AM_MASK[gk];
         assign out_mode = ~pad_ctl_in.dir_input[gk] & PIN_MASK[gk] & ~ana;
         // open-drain releases the line for a high instead of driving it
         assign drv_d.oe_n[gk] = ~(out_mode &
                                   (~om_q[gk] | ~pad_ctl_in.out_data[gk]));
         assign drv_d.level[gk] = pad_ctl_in.out_data[gk] & ~om_q[gk]
                                  & out_mode;
         assign drv_d.pull_up_en[gk] = pad_ctl_in.pull_up_sel[gk] &
                                       PIN_MASK[gk] & ~ana &
                                       (pad_ctl_in.dir_input[gk] |
                                        om_q[gk]);
         assign drv_d.pull_down_en[gk] = pad_ctl_in.pull_down_sel[gk] &
                                         PIN_MASK[gk] & ~ana &
                                         pad_ctl_in.dir_input[gk];
         assign drv_d.analog_en[gk] = ana;
         assign drv_d.open_drain[gk] = om_q[gk] & PIN_MASK[gk];
      end
   endgenerate

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         pad_drv_out.level <= '0;
         pad_drv_out.oe_n <= '1;
         pad_drv_out.pull_up_en <= '0;
         pad_drv_out.pull_down_en <= '0;
         pad_drv_out.analog_en <= AM_RST;
         pad_drv_out.open_drain <= OM_RST;
      end
      else
      begin
         pad_drv_out <= drv_d;
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   property p_om_reset;
      @(posedge clk_in) srst_in |=> (om_q == '0);
   endproperty
   a_om_reset: assert property (p_om_reset)
      else $error("drive mode not cleared by reset");

   property p_am_reset;
      @(posedge clk_in) srst_in |=> (am_q == AM_RST) ##1
         (srst_in || pad_drv_out.analog_en == $past(am_q));
   endproperty
   a_am_reset: assert property (p_am_reset)
      else $error("analog select reset value wrong");

   property p_od_no_high;
      @(posedge clk_in) disable iff (srst_in)
         ##1 ((pad_drv_out.level | ~pad_drv_out.oe_n) &
              $past(om_q) & $past(pad_ctl_in.out_data)) == '0;
   endproperty
   a_od_no_high: assert property (p_od_no_high)
      else $error("open-drain pin driven while high");

   property p_no_analog_h;
      @(posedge clk_in) disable iff (srst_in)
         (pad_drv_out.analog_en & ~AM_MASK) == '0;
   endproperty
   a_no_analog_h: assert property (p_no_analog_h)
      else $error("pin without analog select is analog");

   property p_no_pull_analog;
      @(posedge clk_in) disable iff (srst_in) ((pad_drv_out.pull_up_en |
                          pad_drv_out.pull_down_en) &
                         pad_drv_out.analog_en) == '0;
   endproperty
   a_no_pull_analog: assert property (p_no_pull_analog)
      else $error("pull resistor on analog pin");

   property p_pu_mode;
      @(posedge clk_in) disable iff (srst_in)
         ##1 (pad_drv_out.pull_up_en & ~$past(pad_ctl_in.dir_input) &
              ~$past(om_q)) == '0;
   endproperty
   a_pu_mode: assert property (p_pu_mode)
      else $error("pull-up on push-pull output");

   property p_upper_zero;
      @(posedge clk_in) disable iff (srst_in)
         hrdata_out[31:16] == 16'h0000 &&
         ($past(ap_rd) || hrdata_out == 32'h0000_0000);
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("unused read bits not zero");

   generate
      for (gk = 0; gk < NUM_PORTS; gk++)
      begin : g_chk
         sequence s_om_write;
            wr_om[gk] ##0 !srst_in;
         endsequence
         sequence s_lv_read;
            rd_lv[gk] ##0 !srst_in;
         endsequence

         property p_om_write;
            @(posedge clk_in) disable iff (srst_in)
               s_om_write |=> (om_q[gk] ==
                               ($past(hwdata_in[PORT_W-1:0]) &
                                PIN_MASK[gk])) ##1
               (pad_drv_out.open_drain[gk] == $past(om_q[gk]));
         endproperty
         a_om_write: assert property (p_om_write)
            else $error("drive mode write not applied");

         property p_lv_read;
            @(posedge clk_in) disable iff (srst_in)
               s_lv_read |=> (hrdata_out[PORT_W-1:0] ==
                              ($past(level_q[gk]) & PIN_MASK[gk]));
         endproperty
         a_lv_read: assert property (p_lv_read)
            else $error("level readback wrong");

         property p_lv_write;
            @(posedge clk_in) disable iff (srst_in)
               (dp_wr_q && dp_idx_q == LV_IDX[gk]) |=>
                  ($stable(om_q) && $stable(am_q));
         endproperty
         a_lv_write: assert property (p_lv_write)
            else $error("write to level register changed state");
      end
   endgenerate

   property p_am_read;
      @(posedge clk_in) disable iff (srst_in)
         (rd_am[0] && !dp_wr_q) |=> (hrdata_out[PORT_W-1:0] == $past(am_q[0]));
   endproperty
   a_am_read: assert property (p_am_read)
      else $error("analog select readback wrong");

endmodule : ppm_port_mode

`default_nettype wire

//--- inc/ppm_pkg.sv
// port pin mode package: register map, field masks, reset values, carriers
// assumes one 32-bit AHB-Lite slave window per port group, word aligned
package ppm_pkg;

   // ------------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------------
   localparam int NUM_PORTS = 5;
   localparam int PORT_W = 16;
   localparam int IDX_W = 10;
   localparam int NUM_AM = 4;

   typedef logic [NUM_PORTS-1:0][PORT_W-1:0] ppm_port_word_t;
   typedef logic [NUM_PORTS-1:0][IDX_W-1:0] ppm_idx_list_t;

   // ------------------------------------------------------------------
   // register map (register index; byte address = base + 4 * index)
   // ------------------------------------------------------------------
   localparam logic [31:0] BASE_ADDR = 32'h4004_0000;
   // entry order A, B, C, D, H from index 0 upward
   localparam ppm_idx_list_t OM_IDX = {10'h04E, 10'h046, 10'h044,
                                       10'h042, 10'h040};
   // port H carries no analog select; its slot is never matched
   localparam ppm_idx_list_t AM_IDX = {10'h3FF, 10'h056, 10'h054,
                                       10'h052, 10'h050};
   localparam ppm_idx_list_t LV_IDX = {10'h08E, 10'h086, 10'h084,
                                       10'h082, 10'h080};
   localparam logic [NUM_PORTS-1:0] OM_PRESENT = 5'h1F;
   localparam logic [NUM_PORTS-1:0] AM_PRESENT = 5'h0F;
   localparam logic [NUM_PORTS-1:0] LV_PRESENT = 5'h1F;

   // ------------------------------------------------------------------
   // field masks and reset values
   // ------------------------------------------------------------------
   localparam ppm_port_word_t PIN_MASK = {16'h001F, 16'h03FF, 16'h7FFF,
                                          16'hFFFF, 16'hFFFF};
   localparam ppm_port_word_t AM_MASK = {16'h0000, 16'h0333, 16'h407F,
                                         16'hFC0F, 16'h00FF};
   localparam ppm_port_word_t AM_RST = {16'h0000, 16'h0333, 16'h407F,
                                        16'hFC07, 16'h00FF};
   localparam ppm_port_word_t OM_RST = '0;

   // ------------------------------------------------------------------
   // ahb-lite encodings
   // ------------------------------------------------------------------
   localparam logic [1:0] HTRANS_IDLE = 2'h0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'h0;

   // ------------------------------------------------------------------
   // pad carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      ppm_port_word_t dir_input;
      ppm_port_word_t out_data;
      ppm_port_word_t pull_up_sel;
      ppm_port_word_t pull_down_sel;
   } ppm_pad_ctl_s;

   typedef struct packed {
      ppm_port_word_t level;
      ppm_port_word_t oe_n;
      ppm_port_word_t pull_up_en;
      ppm_port_word_t pull_down_en;
      ppm_port_word_t analog_en;
      ppm_port_word_t open_drain;
   } ppm_pad_drv_s;

endpackage : ppm_pkg

//--- hw/ppm_pin_sync.sv
// pin level synchroniser: four flops per pin, change accepted on agreement
// assumes pin levels are asynchronous to clk_in
`timescale 1ns/1ps
`default_nettype none

module ppm_pin_sync #(
   parameter int W = 80
) (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] level_out
);

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] agree;

   // s1_q is read only by s2_q to keep metastability off the compare
   assign agree = ~(s2_q ^ s3_q);

   always_ff @(posedge clk_in)
   begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         level_out <= '0;
      end
      else
      begin
         level_out <= (agree & s3_q) | (~agree & level_out);
      end
   end

endmodule : ppm_pin_sync

`default_nettype wire

//--- bench/ppm_pin_model.sv
// pin model: outside circuits on every pin of the five ports
// assumes pad_drv_out is registered on clk_in; ext drivers come from the tb
`timescale 1ns/1ps
`default_nettype none

module ppm_pin_model (
   input wire logic clk_in,
   input wire ppm_pkg::ppm_pad_drv_s drv_in,
   input wire ppm_pkg::ppm_port_word_t ext_en_in,
   input wire ppm_pkg::ppm_port_word_t ext_val_in,
   output var ppm_pkg::ppm_port_word_t pin_out
);
   import ppm_pkg::*;
   localparam int N = NUM_PORTS * PORT_W;
   logic [N-1:0] dev_en, lvl, ext_en, ext_v, pu, pd, last_q, pin;
   assign dev_en = ~drv_in.oe_n;
   assign lvl = drv_in.level;
   assign ext_en = ext_en_in;
   assign ext_v = ext_val_in;
   assign pu = drv_in.pull_up_en;
   assign pd = drv_in.pull_down_en;
   assign pin_out = pin;

   // ------------------------------------------------------------------
   // line resolution
   // ------------------------------------------------------------------
   // a line nobody holds flips every cycle so that a stale value is seen
   always_comb
   begin
      for (int i = 0; i < N; i++)
      begin
         if (dev_en[i] && ext_en[i] && (lvl[i] !== ext_v[i]))
            pin[i] = 1'bx;
         else if (dev_en[i])
            pin[i] = lvl[i];
         else if (ext_en[i])
            pin[i] = ext_v[i];
         else if (pu[i])
            pin[i] = 1'b1;
         else if (pd[i])
            pin[i] = 1'b0;
         else
            pin[i] = ~last_q[i];
      end
   end

   always_ff @(posedge clk_in)
      last_q <= pin;
endmodule : ppm_pin_model
`default_nettype wire

//--- bench/tb.sv
// testbench for the port pin mode block: register tasks over ahb-lite
// assumes one slave, hready looped back, pins resolved by ppm_pin_model
`timescale 1ns/1ps
`default_nettype none

module tb;
   import ppm_pkg::*;
   logic clk, srst, hsel, hwrite, hready, hresp;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, d;
   ppm_port_word_t pins, ext_en, ext_val, pat;
   ppm_pad_ctl_s ctl;
   ppm_pad_drv_s drv;
   int n_fail = 0;
   int cmp_count = 0;

   ppm_port_mode ppm_port_mode_inst (.clk_in(clk), .srst_in(srst),
      .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
      .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
      .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
      .hresp_out(hresp), .pin_level_in(pins), .pad_ctl_in(ctl),
      .pad_drv_out(drv));
   ppm_pin_model ppm_pin_model_inst (.clk_in(clk), .drv_in(drv),
      .ext_en_in(ext_en), .ext_val_in(ext_val), .pin_out(pins));

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ------------------------------------------------------------------
   // bus and check tasks
   // ------------------------------------------------------------------
   task automatic ahb(input logic wr, input logic [9:0] idx,
                      input logic [31:0] wd, output logic [31:0] rdat);
      hsel <= 1'b1;
      haddr <= BASE_ADDR + {20'h0, idx, 2'h0};
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      @(posedge clk);
      while (hready !== 1'b1)
         @(posedge clk);
      hsel <= 1'b0;
      htrans <= HTRANS_IDLE;
      hwdata <= wd;
      @(posedge clk);
      while (hready !== 1'b1)
         @(posedge clk);
      rdat = hrdata;
   endtask : ahb

   task automatic wr(input logic [9:0] idx, input logic [31:0] v);
      logic [31:0] dummy;
      ahb(1'b1, idx, v, dummy);
   endtask : wr

   task automatic rd(input logic [9:0] idx, output logic [31:0] v);
      ahb(1'b0, idx, 32'h0, v);
   endtask : rd

   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish

   initial
   begin
      #200000;
      n_fail++;
      tally_and_finish();
   end

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial
   begin
      srst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = HTRANS_IDLE;
      hwrite = 1'b0;
      hwdata = 32'h0;
      ctl = '0;
      ctl.dir_input = '1;
      ext_en = '1;
      ext_val = '0;
      for (int p = 0; p < NUM_PORTS; p++)
         pat[p] = 16'hC3A5 + 16'h1111 * p[15:0];
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      for (int p = 0; p < NUM_PORTS; p++)
      begin
         rd(OM_IDX[p], d);
         chk("drive mode reset", d, 32'h0);
         wr(OM_IDX[p], 32'hFFFF_FFFF);
         rd(OM_IDX[p], d);
         chk("drive mode mask", d, {16'h0, PIN_MASK[p]});
         wr(OM_IDX[p], 32'h0000_5A5A);
         rd(OM_IDX[p], d);
         chk("drive mode bits", d, {16'h0, 16'h5A5A & PIN_MASK[p]});
         chk("open drain pad", {16'h0, drv.open_drain[p]},
             {16'h0, 16'h5A5A & PIN_MASK[p]});
         wr(OM_IDX[p], 32'h0);
      end
      for (int p = 0; p < NUM_AM; p++)
      begin
         rd(AM_IDX[p], d);
         chk("analog reset", d, {16'h0, AM_RST[p]});
         wr(AM_IDX[p], 32'hFFFF_FFFF);
         rd(AM_IDX[p], d);
         chk("analog mask", d, {16'h0, AM_MASK[p]});
         chk("analog pad", {16'h0, drv.analog_en[p]},
             {16'h0, AM_MASK[p]});
         wr(AM_IDX[p], 32'h0);
         rd(AM_IDX[p], d);
         chk("analog clear", d, 32'h0);
      end
      chk("port h analog", {16'h0, drv.analog_en[4]}, 32'h0);
      rd(10'h060, d);
      chk("unmapped read", d, 32'h0);
      // digital inputs driven from outside, then read back
      ext_val <= pat;
      repeat (6) @(posedge clk);
      for (int p = 0; p < NUM_PORTS; p++)
      begin
         rd(LV_IDX[p], d);
         chk("level in", d, {16'h0, pat[p] & PIN_MASK[p]});
         wr(LV_IDX[p], {16'h0, ~pat[p]});
         rd(LV_IDX[p], d);
         chk("level write", d, {16'h0, pat[p] & PIN_MASK[p]});
      end
      // port a as outputs, half open-drain with pull-ups, shared line style
      ext_en[0] <= 16'h0;
      ctl.dir_input[0] <= 16'h0;
      ctl.out_data[0] <= 16'h3C3C;
      ctl.pull_up_sel[0] <= 16'hFFFF;
      wr(OM_IDX[0], 32'h0000_0F0F);
      repeat (6) @(posedge clk);
      chk("oe_n", {16'h0, drv.oe_n[0]}, 32'h0C0C);
      chk("drive level", {16'h0, drv.level[0]}, 32'h3030);
      chk("pull up", {16'h0, drv.pull_up_en[0]}, 32'h0F0F);
      rd(LV_IDX[0], d);
      chk("level out", d, 32'h3C3C);
      wr(AM_IDX[0], 32'h0000_00FF);
      repeat (2) @(posedge clk);
      chk("analog en", {16'h0, drv.analog_en[0]}, 32'h00FF);
      chk("analog pull", {16'h0, drv.pull_up_en[0]}, 32'h0F00);
      chk("analog oe_n", {16'h0, drv.oe_n[0]}, 32'h0CFF);
      // port b inputs held by pull-downs only
      ext_en[1] <= 16'h0;
      ctl.pull_down_sel[1] <= 16'hFFFF;
      repeat (6) @(posedge clk);
      chk("pull down", {16'h0, drv.pull_down_en[1]}, 32'hFFFF);
      chk("no pull up", {16'h0, drv.pull_up_en[1]}, 32'h0);
      rd(LV_IDX[1], d);
      chk("level low", d, 32'h0);
      wr(AM_IDX[1], 32'h0000_FFFF);
      repeat (2) @(posedge clk);
      chk("analog pd", {16'h0, drv.pull_down_en[1]},
          {16'h0, ~AM_MASK[1]});
      chk("hresp", {31'h0, hresp}, {31'h0, HRESP_OKAY});
      chk("hready", {31'h0, hready}, 32'h1);
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
